//--- pkg/pss_map.svh
// register offsets, field positions, clear values and timing counts of the fault summary bank
`ifndef PSS_MAP_SVH
`define PSS_MAP_SVH

// command codes
`define PSS_SUMMARY_BYTE_CODE 8'h78
`define PSS_SUMMARY_WORD_CODE 8'h79

// summary byte / low byte of the summary word
`define PSS_BIT_BUSY 7
`define PSS_BIT_OFF 6
`define PSS_BIT_OUT_OV 5
`define PSS_BIT_OUT_OC 4
`define PSS_BIT_IN_UV 3
`define PSS_BIT_TEMP 2
`define PSS_BIT_CML 1
`define PSS_BIT_UNCAT 0

// upper byte of the summary word
`define PSS_BIT_OUTPUT_VOLTAGE_GROUP_SUMMARY_GRP 15
`define PSS_BIT_OUTPUT_CURRENT_GROUP_SUMMARY_GRP 14
`define PSS_BIT_INPUT_GRP 13
`define PSS_BIT_VENDOR 12
`define PSS_BIT_POWER_GOOD_LIVE_BIT 11
`define PSS_BIT_UNSUP_HI 10
`define PSS_BIT_OTHER 9
`define PSS_BIT_UNSUP_LO 8

// positions inside the detailed status bytes
`define PSS_DET_OUT_OVF 7
`define PSS_DET_OUT_OCF 7
`define PSS_DET_IN_UVF 4

// clear values
`define PSS_CLR_BYTE_BUSY 8'h80
`define PSS_CLR_WORD_BUSY 16'h0080
`define PSS_CLR_WORD_BOTH 16'h0180

// reset value and answer latency in MCLK cycles
`define PSS_SUMMARY_RESET 16'h0000
`define PSS_ANSWER_CYCLES 1

`endif

//--- pkg/pss_pkg.sv
// types shared by both ends of the fault summary link
package pss_pkg;
    // host sequencer states, one-hot
    typedef enum logic [1:0] {
        PSS_H_IDLE = 2'b01,
        PSS_H_WAIT = 2'b10
    } pss_host_state_t;

    // transfer size on the link
    typedef enum logic {
        PSS_SIZE_BYTE = 1'b0,
        PSS_SIZE_WORD = 1'b1
    } pss_size_t;
endpackage

//--- pkg/pss_link_if.sv
// command-level management link between the host end and the status bank
`timescale 1ns/1ps
interface pss_link_if (
    input wire logic MCLK
);
    import pss_pkg::*;
    logic cmd_valid;
    logic cmd_write;
    pss_size_t cmd_size;
    logic [7:0] cmd_code;
    logic [15:0] cmd_data;
    logic rsp_valid;
    logic rsp_err;
    logic [15:0] rsp_data;

    modport dev (
        input cmd_valid, cmd_write, cmd_size, cmd_code, cmd_data,
        output rsp_valid, rsp_err, rsp_data
    );
    modport host (
        output cmd_valid, cmd_write, cmd_size, cmd_code, cmd_data,
        input rsp_valid, rsp_err, rsp_data
    );
endinterface

//--- logic/pss_dev.sv
// device end: summary byte and summary word of the fault status bank
//
// How it works
// - summary byte uses byte read and write
// - byte and word low byte share storage
// - summary bits follow detailed flags, except bits 7, 6, 11, the zero bits 10 and 8, and unknown in bit 0
// - bit 7 latches busy fault, writable
// - bit 6 live: unit not converting
// - bit 5 output overvoltage fault
// - bit 4 output overcurrent fault
// - bit 3 input undervoltage fault
// - bit 2 any temperature fault or warning
// - bit 1 communication, memory or logic fault
// - bit 0 fault not covered above
// - writing 80h to byte clears busy
// - summary word uses word read and write
// - bits 15..13 output, current, input groups
// - bit 12 vendor, bit 9 other faults
// - bit 11 live power-good fault level
// - bits 10 and 8 always zero
// - 0080h clears busy, 0180h also unknown
// - each alerting bit has a mask bit
// - detailed flags cleared elsewhere, summary follows
`timescale 1ns/1ps
`include "pss_map.svh"
module pss_dev
    import pss_pkg::*;
#(
    parameter int DETAIL_W = 8
) (
    // clock and reset
    input wire logic MCLK,
    input wire logic RESETN,
    // management link
    pss_link_if.dev LINK,
    // latched detailed status registers, kept by the fault logic
    input wire logic [DETAIL_W-1:0] OUTPUT_VOLTAGE_GROUP_SUMMARY_DETAIL,
    input wire logic [DETAIL_W-1:0] OUTPUT_CURRENT_GROUP_SUMMARY_DETAIL,
    input wire logic [DETAIL_W-1:0] INPUT_DETAIL,
    input wire logic [DETAIL_W-1:0] TEMP_DETAIL,
    input wire logic [DETAIL_W-1:0] CML_DETAIL,
    input wire logic [DETAIL_W-1:0] MFR_DETAIL,
    input wire logic [DETAIL_W-1:0] OTHER_DETAIL,
    // live conditions
    input wire logic CONVERTING_OFF,
    input wire logic POWER_GOOD_FAULT,
    // one-cycle fault events
    input wire logic BUSY_EVENT,
    input wire logic UNKNOWN_EVENT,
    // alert masking, one bit per summary bit
    input wire logic [15:0] ALERT_MASK,
    // state shown to the rest of the chip
    output logic [15:0] FAULT_SUMMARY_WORD,
    output logic UNKNOWN_FLAG,
    output logic ALERT_N
);
    // the fixed detail positions reach bit 7, so a narrower detail register cannot be served
    if (DETAIL_W < 8) begin : g_bad_width
        $error("pss_dev: DETAIL_W must be at least 8");
    end

    // registers, their next values and the answer flops
    logic [15:0] summary_r;
    logic [15:0] summary_nxt;
    logic busy_r;
    logic busy_nxt;
    logic unknown_r;
    logic unknown_nxt;
    logic alert_n_r;
    logic rsp_valid_r;
    logic rsp_err_r;
    logic [15:0] rsp_data_r;

    // group summaries: any latched flag in the detailed register
    wire output_voltage_group_summary_any = |OUTPUT_VOLTAGE_GROUP_SUMMARY_DETAIL;
    wire output_current_group_summary_any = |OUTPUT_CURRENT_GROUP_SUMMARY_DETAIL;
    wire input_any = |INPUT_DETAIL;
    wire temp_any = |TEMP_DETAIL;
    wire cml_any = |CML_DETAIL;
    wire vendor_any = |MFR_DETAIL;
    wire other_any = |OTHER_DETAIL;

    // single-fault summaries taken straight from the detailed flags
    wire output_overvoltage_summary = OUTPUT_VOLTAGE_GROUP_SUMMARY_DETAIL[`PSS_DET_OUT_OVF];
    wire output_overcurrent_summary = OUTPUT_CURRENT_GROUP_SUMMARY_DETAIL[`PSS_DET_OUT_OCF];
    wire input_undervoltage_summary = INPUT_DETAIL[`PSS_DET_IN_UVF];

    // anything latched that the byte bits above do not already name, one detail bit at a time
    wire [DETAIL_W-1:0] output_voltage_group_summary_rest;
    wire [DETAIL_W-1:0] output_current_group_summary_rest;
    wire [DETAIL_W-1:0] input_rest;
    for (genvar k = 0; k < DETAIL_W; k++) begin : g_rest
        assign output_voltage_group_summary_rest[k] = OUTPUT_VOLTAGE_GROUP_SUMMARY_DETAIL[k] && (k != `PSS_DET_OUT_OVF);
        assign output_current_group_summary_rest[k] = OUTPUT_CURRENT_GROUP_SUMMARY_DETAIL[k] && (k != `PSS_DET_OUT_OCF);
        assign input_rest[k] = INPUT_DETAIL[k] && (k != `PSS_DET_IN_UVF);
    end
    wire uncategorised_fault_summary = (|output_voltage_group_summary_rest) | (|output_current_group_summary_rest) | (|input_rest)
        | vendor_any | other_any | unknown_r;

    // command decode
    wire hit_byte = LINK.cmd_code == `PSS_SUMMARY_BYTE_CODE;
    wire hit_word = LINK.cmd_code == `PSS_SUMMARY_WORD_CODE;
    // a known code with the wrong size is refused like an unknown code, so it cannot half-write
    wire byte_ok = hit_byte && LINK.cmd_size == PSS_SIZE_BYTE;
    wire word_ok = hit_word && LINK.cmd_size == PSS_SIZE_WORD;
    wire size_ok = byte_ok || word_ok;
    wire take = LINK.cmd_valid && size_ok;
    wire wr_take = take && LINK.cmd_write;
    wire rd_take = take && !LINK.cmd_write;

    // only the exact clear values act; any other write is dropped
    wire clr_busy_byte = wr_take && hit_byte && LINK.cmd_data[7:0] == `PSS_CLR_BYTE_BUSY;
    wire clr_busy_word = wr_take && hit_word && LINK.cmd_data == `PSS_CLR_WORD_BUSY;
    wire clr_both_word = wr_take && hit_word && LINK.cmd_data == `PSS_CLR_WORD_BOTH;
    wire clr_busy = clr_busy_byte || clr_busy_word || clr_both_word;

    // set wins over clear so a busy fault in the clearing cycle is kept
    assign busy_nxt = BUSY_EVENT || (busy_r && !clr_busy);
    assign unknown_nxt = UNKNOWN_EVENT || (unknown_r && !clr_both_word);

    // next summary: one copy serves both commands, so byte and word never disagree
    always_comb begin
        summary_nxt = `PSS_SUMMARY_RESET;
        summary_nxt[`PSS_BIT_BUSY] = busy_nxt;
        summary_nxt[`PSS_BIT_OFF] = CONVERTING_OFF;
        summary_nxt[`PSS_BIT_OUT_OV] = output_overvoltage_summary;
        summary_nxt[`PSS_BIT_OUT_OC] = output_overcurrent_summary;
        summary_nxt[`PSS_BIT_IN_UV] = input_undervoltage_summary;
        summary_nxt[`PSS_BIT_TEMP] = temp_any;
        summary_nxt[`PSS_BIT_CML] = cml_any;
        summary_nxt[`PSS_BIT_UNCAT] = uncategorised_fault_summary;
        summary_nxt[`PSS_BIT_OUTPUT_VOLTAGE_GROUP_SUMMARY_GRP] = output_voltage_group_summary_any;
        summary_nxt[`PSS_BIT_OUTPUT_CURRENT_GROUP_SUMMARY_GRP] = output_current_group_summary_any;
        summary_nxt[`PSS_BIT_INPUT_GRP] = input_any;
        summary_nxt[`PSS_BIT_VENDOR] = vendor_any;
        summary_nxt[`PSS_BIT_POWER_GOOD_LIVE_BIT] = POWER_GOOD_FAULT;
        summary_nxt[`PSS_BIT_OTHER] = other_any;
        summary_nxt[`PSS_BIT_UNSUP_HI] = 1'b0;
        summary_nxt[`PSS_BIT_UNSUP_LO] = 1'b0;
    end

    // answer data: the byte read is the low byte of the very same register
    wire [15:0] read_val = hit_byte ? {8'h00, summary_r[7:0]} : summary_r;

    // alert gating per bit: a masked bit still reads back, it only stays off the alert line
    wire [15:0] alert_bits;
    for (genvar b = 0; b < 16; b++) begin : g_alert
        assign alert_bits[b] = summary_nxt[b] && !ALERT_MASK[b];
    end
    wire alert_any = |alert_bits;

    // latched fault flags; both start cleared
    always_ff @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            busy_r <= 1'b0;
            unknown_r <= 1'b0;
        end else begin
            busy_r <= busy_nxt;
            unknown_r <= unknown_nxt;
        end
    end

    // the live bits are registered too, so one read never mixes two sample times
    always_ff @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            summary_r <= `PSS_SUMMARY_RESET;
        end else begin
            summary_r <= summary_nxt;
        end
    end

    // alert line from its own flop so it changes together with the summary output
    always_ff @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            alert_n_r <= 1'b1;
        end else begin
            alert_n_r <= !alert_any;
        end
    end

    // answer one cycle after each command; wrong code or size answers with error
    always_ff @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            rsp_valid_r <= 1'b0;
            rsp_err_r <= 1'b0;
        end else begin
            rsp_valid_r <= LINK.cmd_valid;
            rsp_err_r <= LINK.cmd_valid && !size_ok;
        end
    end

    // read data only on a taken read; zero otherwise keeps the answer lines quiet between answers
    always_ff @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            rsp_data_r <= 16'h0000;
        end else begin
            rsp_data_r <= rd_take ? read_val : 16'h0000;
        end
    end

    // every output leaves straight from a flop
    assign LINK.rsp_valid = rsp_valid_r;
    assign LINK.rsp_err = rsp_err_r;
    assign LINK.rsp_data = rsp_data_r;
    assign FAULT_SUMMARY_WORD = summary_r;
    assign UNKNOWN_FLAG = unknown_r;
    assign ALERT_N = alert_n_r;
endmodule

//--- logic/pss_host.sv
// host end: issues byte and word accesses to the summary registers
`timescale 1ns/1ps
`include "pss_map.svh"
module pss_host
    import pss_pkg::*;
(
    // clock and reset
    input wire logic MCLK,
    input wire logic RESETN,
    // management link
    pss_link_if.host LINK,
    // user request
    input wire logic REQ_VALID,
    input wire logic REQ_WRITE,
    input wire logic REQ_WORD,
    input wire logic [7:0] REQ_CODE,
    input wire logic [15:0] REQ_DATA,
    // user answer
    output logic REQ_READY,
    output logic DONE,
    output logic ERR,
    output logic [15:0] RD_DATA
);
    pss_host_state_t state_r;
    pss_host_state_t state_nxt;
    logic cmd_valid_r;
    logic cmd_write_r;
    pss_size_t cmd_size_r;
    logic [7:0] cmd_code_r;
    logic [15:0] cmd_data_r;
    logic done_r;
    logic err_r;
    logic [15:0] rd_data_r;

    // byte command with byte transfer, word command with word transfer
    wire size_ok = (REQ_CODE == `PSS_SUMMARY_BYTE_CODE && !REQ_WORD)
        || (REQ_CODE == `PSS_SUMMARY_WORD_CODE && REQ_WORD);
    wire idle = state_r == PSS_H_IDLE;
    // the answer cycle counts as busy, so a request held over it is not taken twice
    wire ready = idle && !done_r;
    wire start = ready && REQ_VALID && size_ok;
    wire refuse = ready && REQ_VALID && !size_ok;
    wire finish = state_r == PSS_H_WAIT && LINK.rsp_valid;

    // sequencer
    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            PSS_H_IDLE: begin
                if (start) begin
                    state_nxt = PSS_H_WAIT;
                end
            end
            PSS_H_WAIT: begin
                if (LINK.rsp_valid) begin
                    state_nxt = PSS_H_IDLE;
                end
            end
            default: begin
                state_nxt = PSS_H_IDLE;
            end
        endcase
    end

    // byte writes carry only the low byte, so 80h stays a byte clear
    always_ff @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            state_r <= PSS_H_IDLE;
            cmd_valid_r <= 1'b0;
            cmd_write_r <= 1'b0;
            cmd_size_r <= PSS_SIZE_BYTE;
            cmd_code_r <= 8'h00;
            cmd_data_r <= 16'h0000;
        end else begin
            state_r <= state_nxt;
            cmd_valid_r <= start;
            if (start) begin
                cmd_write_r <= REQ_WRITE;
                cmd_size_r <= REQ_WORD ? PSS_SIZE_WORD : PSS_SIZE_BYTE;
                cmd_code_r <= REQ_CODE;
                cmd_data_r <= REQ_WORD ? REQ_DATA : {8'h00, REQ_DATA[7:0]};
            end
        end
    end

    // answer to the user; a mismatched size never reaches the link
    always_ff @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            done_r <= 1'b0;
            err_r <= 1'b0;
            rd_data_r <= 16'h0000;
        end else begin
            done_r <= finish || refuse;
            if (finish || refuse) begin
                err_r <= refuse || LINK.rsp_err;
                rd_data_r <= finish ? LINK.rsp_data : 16'h0000;
            end
        end
    end

    assign LINK.cmd_valid = cmd_valid_r;
    assign LINK.cmd_write = cmd_write_r;
    assign LINK.cmd_size = cmd_size_r;
    assign LINK.cmd_code = cmd_code_r;
    assign LINK.cmd_data = cmd_data_r;
    assign REQ_READY = idle && !cmd_valid_r && !done_r;
    assign DONE = done_r;
    assign ERR = err_r;
    assign RD_DATA = rd_data_r;
endmodule

//--- tb/pss_checker.sv
// link protocol assertions for the fault summary bank
`timescale 1ns/1ps
`include "pss_map.svh"
module pss_checker
    import pss_pkg::*;
(
    // clock and reset
    input wire logic MCLK,
    input wire logic RESETN,
    // link signals
    input wire logic cmd_valid,
    input wire logic cmd_write,
    input wire pss_size_t cmd_size,
    input wire logic [7:0] cmd_code,
    input wire logic [15:0] cmd_data,
    input wire logic rsp_valid,
    input wire logic rsp_err,
    input wire logic [15:0] rsp_data
);
    default clocking cb @(posedge MCLK);
    endclocking
    default disable iff (!RESETN);
    // code and size must agree, otherwise the bank refuses
    wire good_cmd = (cmd_code == `PSS_SUMMARY_BYTE_CODE && cmd_size == PSS_SIZE_BYTE) ||
        (cmd_code == `PSS_SUMMARY_WORD_CODE && cmd_size == PSS_SIZE_WORD);
    rsp_timing_a: assert property (cmd_valid |=> rsp_valid)
        else $error("missing answer after command");
    answer_cause_a: assert property (rsp_valid |-> $past(cmd_valid))
        else $error("answer without command");
    refuse_err_a: assert property (cmd_valid && !good_cmd |=> rsp_valid && rsp_err)
        else $error("mismatched command not refused");
    accept_ok_a: assert property (cmd_valid && good_cmd |=> !rsp_err)
        else $error("valid command refused");
    byte_upper_a: assert property (cmd_valid && !cmd_write && cmd_size == PSS_SIZE_BYTE
        |=> rsp_data[15:8] == 8'h00)
        else $error("byte read upper half not zero");
    unsup_zero_a: assert property (rsp_valid |-> !rsp_data[10] && !rsp_data[8])
        else $error("unsupported bit set");
    write_quiet_a: assert property (cmd_valid && cmd_write |=> rsp_data == 16'h0000)
        else $error("write returned data");
    idle_zero_a: assert property (!rsp_valid |-> rsp_data == 16'h0000 && !rsp_err)
        else $error("answer lines not idle");
    byte_wdata_a: assert property (cmd_valid && cmd_write && cmd_size == PSS_SIZE_BYTE
        |-> cmd_data[15:8] == 8'h00)
        else $error("byte write carries upper data");
    cmd_legal_a: assert property (cmd_valid |-> good_cmd)
        else $error("host sent a mismatched command");
    host_gap_a: assert property (cmd_valid |=> !cmd_valid [*3])
        else $error("host command too soon");
endmodule

//--- tb/pmbus_status_summary_regs_tb_top.sv
// self-checking bench: host end and status bank joined by the link
`timescale 1ns/1ps
`include "pss_map.svh"
module pmbus_status_summary_regs_tb_top
    import pss_pkg::*;
;
    logic MCLK = 1'b0;
    logic RESETN = 1'b0;
    logic [7:0] vd = 8'h00, id = 8'h00, ind = 8'h00, td = 8'h00, cd = 8'h00, md = 8'h00, od = 8'h00;
    logic off = 1'b0, pg = 1'b0, be = 1'b0, ue = 1'b0, rv = 1'b0, rw = 1'b0, rwd = 1'b0;
    logic [7:0] rc = 8'h00;
    logic [15:0] rd = 16'h0000, mask = 16'h0000, rdata, word;
    logic done, err, unk, alert_n, rdy;
    logic busy_m = 1'b0, unk_m = 1'b0;
    int failures = 0, checks = 0, seed = 84152;
    always #5 MCLK = ~MCLK;
    pss_link_if i_link (.MCLK(MCLK));
    pss_dev i_pss_dev (.MCLK(MCLK), .RESETN(RESETN), .LINK(i_link), .OUTPUT_VOLTAGE_GROUP_SUMMARY_DETAIL(vd), .OUTPUT_CURRENT_GROUP_SUMMARY_DETAIL(id),
        .INPUT_DETAIL(ind), .TEMP_DETAIL(td), .CML_DETAIL(cd), .MFR_DETAIL(md), .OTHER_DETAIL(od),
        .CONVERTING_OFF(off), .POWER_GOOD_FAULT(pg), .BUSY_EVENT(be), .UNKNOWN_EVENT(ue), .ALERT_MASK(mask),
        .FAULT_SUMMARY_WORD(word), .UNKNOWN_FLAG(unk), .ALERT_N(alert_n));
    pss_host i_pss_host (.MCLK(MCLK), .RESETN(RESETN), .LINK(i_link), .REQ_VALID(rv), .REQ_WRITE(rw),
        .REQ_WORD(rwd), .REQ_CODE(rc), .REQ_DATA(rd), .REQ_READY(rdy), .DONE(done), .ERR(err), .RD_DATA(rdata));
    pss_checker i_pss_checker (.MCLK(MCLK), .RESETN(RESETN), .cmd_valid(i_link.cmd_valid),
        .cmd_write(i_link.cmd_write), .cmd_size(i_link.cmd_size), .cmd_code(i_link.cmd_code),
        .cmd_data(i_link.cmd_data), .rsp_valid(i_link.rsp_valid), .rsp_err(i_link.rsp_err),
        .rsp_data(i_link.rsp_data));
    // expected summary, rebuilt from the detailed flags and live inputs
    function automatic logic [15:0] model();
        logic [15:0] m;
        m = 16'h0000;
        m[15] = |vd;
        m[14] = |id;
        m[13] = |ind;
        m[12] = |md;
        m[11] = pg;
        m[9] = |od;
        m[7] = busy_m;
        m[6] = off;
        m[5] = vd[7];
        m[4] = id[7];
        m[3] = ind[4];
        m[2] = |td;
        m[1] = |cd;
        m[0] = |vd[6:0] | |id[6:0] | |ind[3:0] | |ind[7:5] | |md | |od | unk_m;
        return m;
    endfunction
    task automatic chk_data(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            failures++;
            $display("wrong value t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // single-bit results share the wide compare
    task automatic chk_bit(input logic got, input logic exp);
        chk_data({15'h0000, got}, {15'h0000, exp});
    endtask
    task automatic tally_and_finish();
        $display("checks=%0d failures=%0d", checks, failures);
        if (failures == 0 && checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // one host access; done is awaited under a bound, a hang ends the run
    task automatic acc(input logic w, input logic wd, input logic [7:0] c, input logic [15:0] d, input logic e);
        int n;
        @(posedge MCLK);
        rv <= 1'b1;
        rw <= w;
        rwd <= wd;
        rc <= c;
        rd <= d;
        @(posedge MCLK);
        rv <= 1'b0;
        #1;
        for (n = 0; n < 8 && done !== 1'b1; n++) begin
            @(posedge MCLK);
            #1;
        end
        if (done !== 1'b1) begin
            failures++;
            tally_and_finish();
        end
        chk_bit(err, e);
        chk_bit(rdy, 1'b0);
        @(posedge MCLK);
        #1;
        chk_bit(rdy, 1'b1);
    endtask
    // read back one register, the summary output and the alert line
    task automatic rd_cmp(input logic wd);
        acc(1'b0, wd, wd ? `PSS_SUMMARY_WORD_CODE : `PSS_SUMMARY_BYTE_CODE, 16'h0000, 1'b0);
        chk_data(rdata, wd ? model() : model() & 16'h00ff);
        chk_data(word, model());
        chk_bit(alert_n, ~|(model() & ~mask));
    endtask
    // event pulses last one cycle, as the fault logic gives them
    task automatic pulse(input logic b, input logic u);
        @(posedge MCLK);
        be <= b;
        ue <= u;
        @(posedge MCLK);
        be <= 1'b0;
        ue <= 1'b0;
        busy_m = busy_m | b;
        unk_m = unk_m | u;
    endtask
    initial begin
        repeat (8) @(posedge MCLK);
        RESETN <= 1'b1;
        rd_cmp(1'b1);
        // random flags, live bits and masks, read both ways
        repeat (12) begin
            @(posedge MCLK);
            vd <= 8'($random(seed)) & 8'hfc;
            id <= 8'($random(seed)) & 8'ha0;
            ind <= 8'($random(seed)) & 8'hb8;
            {td, cd, md, od} <= 32'($random(seed));
            {off, pg} <= 2'($random(seed));
            mask <= 16'($random(seed));
            rd_cmp(1'b1);
            rd_cmp(1'b0);
        end
        // detailed flags cleared: summary follows; other writes ignored
        @(posedge MCLK);
        {vd, id, ind, td, cd, md, od, off, pg} <= '0;
        acc(1'b1, 1'b1, `PSS_SUMMARY_WORD_CODE, 16'hff7f, 1'b0);
        rd_cmp(1'b1);
        pulse(1'b1, 1'b0);
        acc(1'b1, 1'b0, `PSS_SUMMARY_BYTE_CODE, 16'h0040, 1'b0);
        rd_cmp(1'b0);
        acc(1'b1, 1'b0, `PSS_SUMMARY_BYTE_CODE, 16'h0080, 1'b0);
        busy_m = 1'b0;
        rd_cmp(1'b0);
        pulse(1'b1, 1'b1);
        acc(1'b1, 1'b1, `PSS_SUMMARY_WORD_CODE, 16'h0080, 1'b0);
        busy_m = 1'b0;
        rd_cmp(1'b1);
        chk_bit(unk, 1'b1);
        pulse(1'b1, 1'b0);
        acc(1'b1, 1'b1, `PSS_SUMMARY_WORD_CODE, 16'h0180, 1'b0);
        {busy_m, unk_m} = 2'b00;
        rd_cmp(1'b1);
        chk_bit(unk, 1'b0);
        // reset in mid-run drops the latched busy and unknown flags
        pulse(1'b1, 1'b1);
        @(posedge MCLK);
        RESETN <= 1'b0;
        repeat (2) @(posedge MCLK);
        RESETN <= 1'b1;
        {busy_m, unk_m} = 2'b00;
        @(posedge MCLK);
        #1;
        chk_data(word, model());
        chk_bit(unk, 1'b0);
        chk_bit(alert_n, 1'b1);
        // refusals: size and code disagree, or unknown code
        pulse(1'b1, 1'b0);
        acc(1'b0, 1'b0, `PSS_SUMMARY_WORD_CODE, 16'h0000, 1'b1);
        acc(1'b0, 1'b1, `PSS_SUMMARY_BYTE_CODE, 16'h0000, 1'b1);
        acc(1'b1, 1'b1, 8'h7a, 16'h0080, 1'b1);
        rd_cmp(1'b1);
        tally_and_finish();
    end
endmodule
